// ### common/frame_fifo_pkg.sv
// Constants shared by the single-clock frame store and its helpers.
package frame_fifo_pkg;
    // Word width and frame memory geometry: 2^21 words of 36 bits.
    localparam int DATA_W = 36;
    localparam int ADDR_W = 21;
    localparam int COUNT_W = ADDR_W + 1;
    localparam logic [COUNT_W-1:0] DEPTH_CNT = 22'h20_0000;
    localparam logic [COUNT_W-1:0] COUNT_EMPTY = 22'h00_0000;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 22'h00_0001;
    localparam logic [ADDR_W-1:0] PTR_ZERO = 21'h00_0000;
    localparam logic [ADDR_W-1:0] PTR_STEP = 21'h00_0001;
    localparam logic [DATA_W-1:0] DATA_ZERO = 36'h0_0000_0000;
    // Configuration register: width and value after a master reset.
    localparam int CFG_W = 8;
    localparam logic [CFG_W-1:0] CFG_DEFAULT = 8'h00;
    // Serial configuration pins passed through the synchroniser.
    localparam int SER_PINS = 3;
    localparam int SER_SCLK = 0;
    localparam int SER_SEN = 1;
    localparam int SER_SDI = 2;
endpackage

// ### hdl/pin_sync.sv
// Two-stage synchroniser for asynchronous input pins.
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Asynchronous pins in, synchronised levels out.
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule // pin_sync

// ### hdl/frame_fifo.sv
// Frame store FIFO with mailbox bypass, resets and configuration register.
`timescale 1ns/1ns
module frame_fifo (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Device resets, active low.
    input wire logic master_reset_n_i,
    input wire logic partial_reset_n_i,
    // Write port.
    input wire logic write_enable_n_i,
    input wire logic input_capture_enable_n_i,
    input wire logic [frame_fifo_pkg::DATA_W-1:0] wr_data_i,
    // Read port.
    input wire logic read_enable_n_i,
    input wire logic output_drive_enable_n_i,
    output logic [frame_fifo_pkg::DATA_W-1:0] rd_data_o,
    output logic output_valid_n_o,
    // Path selects.
    input wire logic load_select_i,
    input wire logic mailbox_select_i,
    // Serial configuration pins.
    input wire logic cfg_sclk_i,
    input wire logic cfg_sen_n_i,
    input wire logic cfg_sdi_i,
    // Status.
    output logic empty_flag_o,
    output logic full_flag_o,
    output logic [frame_fifo_pkg::CFG_W-1:0] cfg_value_o
);
    typedef struct packed {
        logic [frame_fifo_pkg::ADDR_W-1:0] wr_ptr;
        logic [frame_fifo_pkg::ADDR_W-1:0] rd_ptr;
        logic [frame_fifo_pkg::COUNT_W-1:0] count;
        logic [frame_fifo_pkg::DATA_W-1:0] rd_data;
        logic valid;
        logic [frame_fifo_pkg::CFG_W-1:0] cfg;
        logic sclk_prev;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [frame_fifo_pkg::DATA_W-1:0] mem [frame_fifo_pkg::DEPTH_CNT];
    logic [frame_fifo_pkg::DATA_W-1:0] head_word;
    logic [frame_fifo_pkg::SER_PINS-1:0] ser_sync;
    logic any_reset;
    logic empty;
    logic full;
    logic wr_try;
    logic rd_try;
    logic wr_go;
    logic wr_store;
    logic rd_go;
    logic rd_show;
    logic mbox_go;
    logic cfg_wr;
    logic cfg_rd;
    logic sclk_rise;

    // Serial configuration pins come from another clock; synchronise them.
    pin_sync #(
        .WIDTH(frame_fifo_pkg::SER_PINS)
    ) u_ser_sync (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .pin_i({cfg_sdi_i, cfg_sen_n_i, cfg_sclk_i}),
        .sync_o(ser_sync)
    );

    // Decode of requests, paths and flags.
    always_comb begin
        any_reset = rst_i || !master_reset_n_i || !partial_reset_n_i;
        empty = (s_q.count == frame_fifo_pkg::COUNT_EMPTY);
        full = (s_q.count == frame_fifo_pkg::DEPTH_CNT);
        wr_try = !write_enable_n_i;
        rd_try = !read_enable_n_i;
        // Memory path only when loading data and not in mailbox mode.
        wr_go = wr_try && load_select_i && !mailbox_select_i && !full;
        wr_store = wr_go && !input_capture_enable_n_i;
        rd_go = rd_try && load_select_i && !mailbox_select_i && !empty;
        rd_show = rd_go && !output_drive_enable_n_i;
        mbox_go = wr_try && mailbox_select_i && !input_capture_enable_n_i;
        cfg_wr = wr_try && !load_select_i && !mailbox_select_i
            && !input_capture_enable_n_i;
        cfg_rd = rd_try && !load_select_i && !mailbox_select_i
            && !output_drive_enable_n_i;
        sclk_rise = ser_sync[frame_fifo_pkg::SER_SCLK] && !s_q.sclk_prev;
    end

    // Next state of pointers, count, output register and configuration.
    always_comb begin
        s_d = s_q;
        s_d.sclk_prev = ser_sync[frame_fifo_pkg::SER_SCLK];
        s_d.valid = 1'b0;
        // Pointer advances even when capture is masked, skipping the slot.
        if (wr_go) begin
            s_d.wr_ptr = s_q.wr_ptr + frame_fifo_pkg::PTR_STEP;
        end
        // A skipped read still consumes the word.
        if (rd_go) begin
            s_d.rd_ptr = s_q.rd_ptr + frame_fifo_pkg::PTR_STEP;
        end
        if (wr_go && !rd_go) begin
            s_d.count = s_q.count + frame_fifo_pkg::COUNT_ONE;
        end else if (rd_go && !wr_go) begin
            s_d.count = s_q.count - frame_fifo_pkg::COUNT_ONE;
        end
        // Output register: memory word first, then configuration, mailbox.
        if (rd_show) begin
            s_d.rd_data = head_word;
            s_d.valid = 1'b1;
        end else if (cfg_rd) begin
            s_d.rd_data = {{(frame_fifo_pkg::DATA_W
                - frame_fifo_pkg::CFG_W){1'b0}}, s_q.cfg};
            s_d.valid = 1'b1;
        end else if (mbox_go) begin
            s_d.rd_data = wr_data_i;
            s_d.valid = 1'b1;
        end
        // Parallel load wins over a serial bit in the same cycle.
        if (cfg_wr) begin
            s_d.cfg = wr_data_i[frame_fifo_pkg::CFG_W-1:0];
        end else if (sclk_rise && !ser_sync[frame_fifo_pkg::SER_SEN]) begin
            s_d.cfg = {s_q.cfg[frame_fifo_pkg::CFG_W-2:0],
                ser_sync[frame_fifo_pkg::SER_SDI]};
        end
        // Both resets empty the store; only master and core reset touch cfg.
        if (any_reset) begin
            s_d.wr_ptr = frame_fifo_pkg::PTR_ZERO;
            s_d.rd_ptr = frame_fifo_pkg::PTR_ZERO;
            s_d.count = frame_fifo_pkg::COUNT_EMPTY;
            s_d.rd_data = frame_fifo_pkg::DATA_ZERO;
            s_d.valid = 1'b0;
            s_d.cfg = s_q.cfg;
        end
        if (rst_i || !master_reset_n_i) begin
            s_d.cfg = frame_fifo_pkg::CFG_DEFAULT;
        end
    end

    // State register.
    always_ff @(posedge core_clk_i) begin
        s_q <= s_d;
    end

    // Frame memory; a masked write leaves the location untouched.
    always_ff @(posedge core_clk_i) begin
        if (wr_store && !any_reset) begin
            mem[s_q.wr_ptr] <= wr_data_i;
        end
    end

    assign head_word = mem[s_q.rd_ptr];
    assign rd_data_o = s_q.rd_data;
    assign output_valid_n_o = !s_q.valid;
    assign empty_flag_o = empty;
    assign full_flag_o = full;
    assign cfg_value_o = s_q.cfg;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (any_reset);

    // Sequences used by the multi-step checks below.
    sequence lone_store_s;
        wr_store && empty && !rd_go;
    endsequence
    sequence fetch_s;
        rd_show;
    endsequence

    a_fifo_order: assert property (
        fetch_s |=> rd_data_o == $past(head_word) && !output_valid_n_o)
        else $error("read word is not the head of the store");
    a_write_store: assert property (
        lone_store_s |=> head_word == $past(wr_data_i) && !empty_flag_o)
        else $error("stored word not found at the head");
    a_empty_flag: assert property (
        wr_go && !rd_go && empty |=> !empty_flag_o ##0
            s_q.count == frame_fifo_pkg::COUNT_ONE)
        else $error("empty flag did not drop after a write");
    a_mailbox_path: assert property (
        mbox_go && !rd_show && !cfg_rd |=> rd_data_o == $past(wr_data_i)
            && $stable(s_q.wr_ptr) && $stable(s_q.count))
        else $error("mailbox word not passed or memory touched");
    a_skip_advance: assert property (
        wr_go && input_capture_enable_n_i |=>
            s_q.wr_ptr == $past(s_q.wr_ptr) + frame_fifo_pkg::PTR_STEP)
        else $error("masked write did not advance the pointer");
    a_read_skip: assert property (
        rd_go && output_drive_enable_n_i && !cfg_rd && !mbox_go |=>
            output_valid_n_o && $stable(rd_data_o))
        else $error("skipped read changed the output");
    a_full_hold: assert property (
        full && wr_try && load_select_i && !rd_go |=>
            $stable(s_q.wr_ptr) && full_flag_o)
        else $error("write when full changed the store");
    a_config_load: assert property (
        cfg_wr |=> cfg_value_o == $past(wr_data_i[frame_fifo_pkg::CFG_W-1:0]))
        else $error("parallel configuration load failed");

    // Reset checks are not disabled by the reset they watch.
    a_reset_clear: assert property (@(posedge core_clk_i)
        disable iff (1'b0)
        any_reset |=> rd_data_o == frame_fifo_pkg::DATA_ZERO
            && empty_flag_o && !full_flag_o && output_valid_n_o
            && s_q.rd_ptr == frame_fifo_pkg::PTR_ZERO
            && s_q.wr_ptr == frame_fifo_pkg::PTR_ZERO)
        else $error("reset did not clear pointers, flags and output");
    a_master_default: assert property (@(posedge core_clk_i)
        disable iff (1'b0)
        !master_reset_n_i |=> cfg_value_o == frame_fifo_pkg::CFG_DEFAULT)
        else $error("master reset did not restore configuration");
    a_partial_keep: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        !partial_reset_n_i && master_reset_n_i |=> $stable(cfg_value_o))
        else $error("partial reset changed configuration");
endmodule // frame_fifo

// ### bench/video_port_model.sv
// Port model of the video logic that feeds and drains the frame store.
`timescale 1ns/1ns
module video_port_model (
    // Clock.
    input wire logic core_clk_i,
    // Device resets.
    output logic master_reset_n_o,
    output logic partial_reset_n_o,
    // Port controls and write data.
    output logic write_enable_n_o,
    output logic input_capture_enable_n_o,
    output logic read_enable_n_o,
    output logic output_drive_enable_n_o,
    output logic load_select_o,
    output logic mailbox_select_o,
    output logic [frame_fifo_pkg::DATA_W-1:0] wr_data_o,
    // Serial configuration pins.
    output logic cfg_sclk_o,
    output logic cfg_sen_n_o,
    output logic cfg_sdi_o
);
    logic [5:0] ctl_q = 6'h3e;
    // Both ports run from the one core clock, so the ratio is one.
    assign {write_enable_n_o, input_capture_enable_n_o, read_enable_n_o,
        output_drive_enable_n_o, load_select_o, mailbox_select_o} = ctl_q;
    // Everything idle at time zero.
    initial begin
        {master_reset_n_o, partial_reset_n_o} = 2'h3;
        wr_data_o = 36'h0_0000_0000;
        {cfg_sclk_o, cfg_sen_n_o, cfg_sdi_o} = 3'h2;
    end
    // Sets controls and data just after a falling edge.
    task automatic step(input logic [5:0] ctl, input logic [35:0] d);
        @(negedge core_clk_i);
        ctl_q = ctl;
        wr_data_o = d;
    endtask
    // Releases the port; the data bus then shows the inverse word.
    task automatic idle();
        @(negedge core_clk_i);
        ctl_q = 6'h3e;
        wr_data_o = ~wr_data_o;
    endtask
    // Pulses the master or the partial reset for one edge.
    task automatic pulse(input logic master);
        @(negedge core_clk_i);
        master_reset_n_o = ~master;
        partial_reset_n_o = master;
        @(negedge core_clk_i);
        {master_reset_n_o, partial_reset_n_o} = 2'h3;
    endtask
    // Shifts a byte MSB first; the serial clock stands low between frames.
    task automatic shift_cfg(input logic [7:0] v);
        @(negedge core_clk_i);
        cfg_sen_n_o = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            cfg_sdi_o = v[i];
            repeat (4) @(negedge core_clk_i);
            cfg_sclk_o = 1'b1;
            repeat (4) @(negedge core_clk_i);
            cfg_sclk_o = 1'b0;
        end
        repeat (4) @(negedge core_clk_i);
        cfg_sen_n_o = 1'b1;
        cfg_sdi_o = ~cfg_sdi_o;
    endtask
endmodule // video_port_model

// ### bench/frame_fifo_tb_top.sv
// Self-checking bench for the frame store driven by its port model.
`timescale 1ns/1ns
module frame_fifo_tb_top;
    // Control codes: write_n capture_n read_n drive_n load mailbox.
    localparam logic [5:0] WR = 6'h0e, WM = 6'h1e, RD = 6'h32, RS = 6'h36;
    localparam logic [5:0] CW = 6'h0c, CR = 6'h30, MAIL = 6'h0f;
    logic core_clk_i, rst_i, mr_n, pr_n, ls, mbs;
    logic wreq_n, cap_n, rreq_n, drv_n, sclk, sen_n, sdi, valid_n, empty, full;
    logic [35:0] wd, rd;
    logic [7:0] cfg;
    int num_errors = 0, n_tests = 0;
    video_port_model m (.core_clk_i(core_clk_i), .master_reset_n_o(mr_n),
        .partial_reset_n_o(pr_n), .write_enable_n_o(wreq_n),
        .input_capture_enable_n_o(cap_n), .read_enable_n_o(rreq_n),
        .output_drive_enable_n_o(drv_n), .load_select_o(ls),
        .mailbox_select_o(mbs), .wr_data_o(wd), .cfg_sclk_o(sclk),
        .cfg_sen_n_o(sen_n), .cfg_sdi_o(sdi));
    frame_fifo dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .master_reset_n_i(mr_n), .partial_reset_n_i(pr_n),
        .write_enable_n_i(wreq_n), .input_capture_enable_n_i(cap_n),
        .wr_data_i(wd), .read_enable_n_i(rreq_n),
        .output_drive_enable_n_i(drv_n),
        .rd_data_o(rd), .output_valid_n_o(valid_n), .load_select_i(ls),
        .mailbox_select_i(mbs), .cfg_sclk_i(sclk), .cfg_sen_n_i(sen_n),
        .cfg_sdi_i(sdi), .empty_flag_o(empty), .full_flag_o(full),
        .cfg_value_o(cfg));
    // Clock source.
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    // Prints the counts and the verdict, then stops.
    task automatic test_done();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Compares empty, full and valid_n as one group.
    task automatic st(input logic [2:0] exp);
        chk({33'h0_0000_0000, empty, full, valid_n},
            {33'h0_0000_0000, exp});
    endtask
    // One transfer followed by a released cycle in which results settle.
    task automatic op(input logic [5:0] c, input logic [35:0] d);
        m.step(c, d);
        m.idle();
    endtask
    // Back-to-back writes with a masked slot, then reads with a skip.
    task automatic t_order();
        m.step(WR, 36'h1_2345_6789);
        m.step(WM, 36'h2_2222_2222);
        m.step(WR, 36'h3_3333_3333);
        m.idle();
        st(3'h1);
        op(RD, 36'h0_0000_0000);
        chk(rd, 36'h1_2345_6789);
        st(3'h0);
        op(RS, 36'h0_0000_0000);
        chk(rd, 36'h1_2345_6789);
        st(3'h1);
        op(RD, 36'h0_0000_0000);
        chk(rd, 36'h3_3333_3333);
        st(3'h4);
        op(RD, 36'h0_0000_0000);
        chk(rd, 36'h3_3333_3333);
        st(3'h5);
    endtask
    // Main sequence: reset held for 16 cycles, then every scenario.
    initial begin
        rst_i = 1'b1;
        repeat (16) @(negedge core_clk_i);
        rst_i = 1'b0;
        chk(rd, 36'h0_0000_0000);
        st(3'h5);
        t_order();
        op(CW, 36'hf_ffff_ffa5);
        chk({28'h000_0000, cfg}, 36'h0_0000_00a5);
        st(3'h5);
        op(CR, 36'h0_0000_0000);
        chk(rd, 36'h0_0000_00a5);
        op(WR, 36'h4_4444_4444);
        m.pulse(1'b0);
        st(3'h5);
        chk(rd, 36'h0_0000_0000);
        chk({28'h000_0000, cfg}, 36'h0_0000_00a5);
        op(WR, 36'h5_5555_5555);
        op(RD, 36'h0_0000_0000);
        chk(rd, 36'h5_5555_5555);
        op(MAIL, 36'h6_6666_6666);
        chk(rd, 36'h6_6666_6666);
        st(3'h4);
        m.shift_cfg(8'h3c);
        chk({28'h000_0000, cfg}, 36'h0_0000_003c);
        m.pulse(1'b1);
        chk({28'h000_0000, cfg}, 36'h0_0000_0000);
        st(3'h5);
        test_done();
    end
    // Watchdog: the whole run needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge core_clk_i);
        num_errors++;
        test_done();
    end
endmodule // frame_fifo_tb_top
